// [rtl/ubdiv_core.sv]
// divider datapath: unsigned binary and bcd, single and double word
// assumes the sequencer holds a request for one cycle with i_start and
// waits for o_done before the next one
`timescale 1ns/10ps
module ubdiv_core (
  input wire logic I_SYS_CLK,                // 200 MHz clock
  input wire logic I_RST,                    // sync reset, high
  input wire logic I_START,                  // one-cycle request strobe
  input ubdiv_pkg::ubdiv_req_s I_REQ,        // opcode and operands
  output logic O_BUSY,                       // instruction in progress
  output logic O_DONE,                       // one-cycle flags valid pulse
  output logic O_WR_EN,                      // one-cycle result write
  output ubdiv_pkg::ubdiv_rsp_s O_RSP        // results and flags
);
  import ubdiv_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // combinational helpers

  function automatic logic bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (v[i*4 +: 4] > UBDIV_BCD_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : bcd_ok

  // double dabble, one bit per step would cost cycles; this is one shot
  function automatic logic [31:0] to_bcd(input logic [31:0] b);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      for (int d = 0; d < 8; d++) begin
        if (r[d*4 +: 4] > 4'h4) begin
          r[d*4 +: 4] = r[d*4 +: 4] + 4'h3;
        end
      end
      r = {r[30:0], b[i]};
    end
    return r;
  endfunction : to_bcd

  function automatic logic [31:0] to_bin(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int d = 7; d >= 0; d--) begin
      r = 32'((r << 3) + (r << 1)) + {28'h000_0000, v[d*4 +: 4]};
    end
    return r;
  endfunction : to_bin

  ////////////////////////////////////////////////////////////////////////
  // sequencing and restoring division

  ubdiv_state_e st_q, st_d;
  logic [31:0] dvd_q, dvd_d;
  logic [31:0] dvs_q, dvs_d;
  logic [32:0] rem_q, rem_d;
  logic [5:0] cnt_q, cnt_d;
  logic bcd_q, bcd_d;
  logic dbl_q, dbl_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic wr_q, wr_d;
  ubdiv_rsp_s rsp_q, rsp_d;
  logic is_div, is_bcd, is_dbl, ops_ok, zero_dvs;
  logic [31:0] a_in, b_in;
  logic [32:0] trial;
  logic [31:0] q_fin, r_fin;
  logic [31:0] dvd_bin;

  always_comb begin
    is_bcd = (I_REQ.opcode == UBDIV_OP_B) || (I_REQ.opcode == UBDIV_OP_BL);
    is_dbl = (I_REQ.opcode == UBDIV_OP_UL) || (I_REQ.opcode == UBDIV_OP_BL);
    is_div = (I_REQ.opcode == UBDIV_OP_U) || (I_REQ.opcode == UBDIV_OP_UL)
             || is_bcd;
    // single width ignores the upper half of each operand
    a_in = is_dbl ? I_REQ.dividend_operand
                  : {16'h0000, I_REQ.dividend_operand[15:0]};
    b_in = is_dbl ? I_REQ.divisor_operand
                  : {16'h0000, I_REQ.divisor_operand[15:0]};
    ops_ok = !is_bcd || (bcd_ok(a_in) && bcd_ok(b_in));
    zero_dvs = (b_in == 32'h0000_0000);
    trial = {rem_q[31:0], dvd_q[31]} - {1'b0, dvs_q};
    q_fin = bcd_q ? to_bcd(dvd_q) : dvd_q;
    r_fin = bcd_q ? to_bcd(rem_q[31:0]) : rem_q[31:0];
    // a function result cannot be part-selected, so it is named here
    dvd_bin = to_bin(dvd_q);

    st_d = st_q;
    dvd_d = dvd_q;
    dvs_d = dvs_q;
    rem_d = rem_q;
    cnt_d = cnt_q;
    bcd_d = bcd_q;
    dbl_d = dbl_q;
    busy_d = busy_q;
    done_d = 1'b0;
    wr_d = 1'b0;
    rsp_d = rsp_q;
    case (st_q)
      UBDIV_IDLE: begin
        if (I_START && is_div) begin
          bcd_d = is_bcd;
          dbl_d = is_dbl;
          dvd_d = a_in;
          dvs_d = b_in;
          busy_d = 1'b1;
          rsp_d.words = is_dbl ? 2'b10 : 2'b01;
          if (!ops_ok || zero_dvs) begin
            // result words kept as they were: no write strobe
            rsp_d.fault_flag_label = 1'b1;
            st_d = UBDIV_DONE;
          end else begin
            rsp_d.fault_flag_label = 1'b0;
            st_d = is_bcd ? UBDIV_CONV : UBDIV_DIV;
          end
        end
      end
      UBDIV_CONV: begin
        dvd_d = dvd_bin;
        dvs_d = to_bin(dvs_q);
        st_d = UBDIV_DIV;
        rem_d = 33'h0_0000_0000;
        cnt_d = dbl_q ? UBDIV_CNT_W2 : UBDIV_CNT_W1;
      end
      UBDIV_DIV: begin
        if (cnt_q == 6'h00) begin
          st_d = UBDIV_BACK;
        end else begin
          // restoring step; dividend register fills with quotient bits
          if (!trial[32]) begin
            rem_d = trial;
            dvd_d = {dvd_q[30:0], 1'b1};
          end else begin
            rem_d = {rem_q[31:0], dvd_q[31]};
            dvd_d = {dvd_q[30:0], 1'b0};
          end
          cnt_d = cnt_q - 6'h01;
        end
      end
      UBDIV_BACK: begin
        rsp_d.quotient = q_fin;
        rsp_d.remainder = r_fin;
        rsp_d.zero_flag_label = ~|q_fin;
        rsp_d.negative = !bcd_q &&
                         (dbl_q ? q_fin[31] : q_fin[15]);
        wr_d = 1'b1;
        st_d = UBDIV_DONE;
      end
      UBDIV_DONE: begin
        done_d = 1'b1;
        busy_d = 1'b0;
        st_d = UBDIV_IDLE;
      end
      default: begin
        st_d = UBDIV_IDLE;
      end
    endcase
    // unsigned, single or double width: skip the conversion state, load here
    if (st_q == UBDIV_IDLE && st_d == UBDIV_DIV) begin
      rem_d = 33'h0_0000_0000;
      cnt_d = is_dbl ? UBDIV_CNT_W2 : UBDIV_CNT_W1;
      dvd_d = is_dbl ? a_in : {a_in[15:0], 16'h0000};
    end
    if (st_q == UBDIV_CONV && !dbl_q) begin
      dvd_d = {dvd_bin[15:0], 16'h0000};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      st_q <= UBDIV_IDLE;
      dvd_q <= 32'h0000_0000;
      dvs_q <= 32'h0000_0000;
      rem_q <= 33'h0_0000_0000;
      cnt_q <= 6'h00;
      bcd_q <= 1'b0;
      dbl_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      wr_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      st_q <= st_d;
      dvd_q <= dvd_d;
      dvs_q <= dvs_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
      bcd_q <= bcd_d;
      dbl_q <= dbl_d;
      busy_q <= busy_d;
      done_q <= done_d;
      wr_q <= wr_d;
      rsp_q <= rsp_d;
    end
  end

  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_WR_EN = wr_q;
  assign O_RSP = rsp_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence s_fault_req;
    I_START && is_div && !busy_q && (!ops_ok || zero_dvs);
  endsequence

  fault_no_write_a: assert property (s_fault_req |=> !O_WR_EN [*2])
    else $error("result written after a faulted divide");
  fault_flag_set_a: assert property (s_fault_req |=> ##1 O_DONE &&
      O_RSP.fault_flag_label)
    else $error("fault flag missing on bad operands");
  zero_dvs_a: assert property (I_START && is_div && !busy_q && zero_dvs
      |-> ##2 O_RSP.fault_flag_label)
    else $error("zero divisor not flagged");
  bcd_bad_a: assert property (I_START && is_bcd && !busy_q && !ops_ok
      |=> ##1 O_RSP.fault_flag_label)
    else $error("non bcd operand not flagged");
  write_done_a: assert property (O_WR_EN |=> O_DONE)
    else $error("done did not follow write");
  zero_flag_a: assert property (O_WR_EN |-> O_RSP.zero_flag_label ==
      (O_RSP.quotient == 32'h0000_0000))
    else $error("zero flag disagrees with quotient");
  neg_flag_a: assert property (O_WR_EN && !bcd_q && !dbl_q
      |-> O_RSP.negative == O_RSP.quotient[15])
    else $error("negative flag disagrees with quotient");
  div_math_a: assert property (O_WR_EN && !bcd_q |->
      O_RSP.remainder < dvs_q)
    else $error("remainder not below divisor");
  good_write_a: assert property (I_START && is_div && !busy_q && ops_ok
      && !zero_dvs && !is_bcd && !is_dbl |-> ##19 O_WR_EN)
    else $error("single divide write not on time");
endmodule : ubdiv_core

// [rtl/ubdiv_pkg.sv]
// constants, opcodes and carriers of the unsigned and bcd divider
// assumes a sequencer that presents one instruction at a time
// Function
// - single-word unsigned divide; quotient to word 0, remainder to word 1.
// - double-word unsigned divide; quotient words 0-1, remainder words 2-3.
// - unsigned divides raise error on zero divisor, otherwise clear it.
// - unsigned divides raise zero flag when the quotient is zero.
// - unsigned divides raise negative flag when quotient top bit is one.
// - single-word bcd divide on 4 digits; bcd quotient and remainder.
// - double-word bcd divide on 8 digits; quotient 0-1, remainder 2-3.
// - single bcd divide errors on non-bcd digit or zero divisor.
// - double bcd divide errors on any non-bcd digit or zero divisor.
// - single bcd divide zero flag only when the quotient word is zero.
// - double bcd divide zero flag only when both quotient words are zero.
package ubdiv_pkg;
  localparam int unsigned UBDIV_W = 32;
  localparam int unsigned UBDIV_HW = 16;
  localparam logic [5:0] UBDIV_CNT_W1 = 6'h10;
  localparam logic [5:0] UBDIV_CNT_W2 = 6'h20;
  localparam logic [9:0] UBDIV_OP_U = 10'h1B0;   // 432
  localparam logic [9:0] UBDIV_OP_UL = 10'h1B1;  // 433
  localparam logic [9:0] UBDIV_OP_B = 10'h1B2;   // 434
  localparam logic [9:0] UBDIV_OP_BL = 10'h1B3;  // 435
  localparam logic [3:0] UBDIV_BCD_MAX = 4'h9;

  typedef enum logic [2:0] {
    UBDIV_IDLE = 3'b000,
    UBDIV_CONV = 3'b001,
    UBDIV_DIV = 3'b010,
    UBDIV_BACK = 3'b011,
    UBDIV_DONE = 3'b100
  } ubdiv_state_e;

  typedef struct packed {
    logic [9:0] opcode;
    logic [31:0] dividend_operand;
    logic [31:0] divisor_operand;
  } ubdiv_req_s;

  typedef struct packed {
    logic [31:0] quotient;
    logic [31:0] remainder;
    logic [1:0] words;     // 01: two words, 10: four words
    logic fault_flag_label;
    logic zero_flag_label;
    logic negative;
  } ubdiv_rsp_s;
endpackage : ubdiv_pkg

// [verif/ubdiv_mem.sv]
// operand memory model: holds the result words r to r+3 written by the core
// assumes o_wr_en pulses once for each instruction that completes without a fault
`timescale 1ns/10ps
module ubdiv_mem (
  input wire logic i_clk,              // system clock
  input wire logic i_rst,              // sync reset, high
  input wire logic i_wr_en,            // result write strobe
  input ubdiv_pkg::ubdiv_rsp_s i_rsp,  // result words and width
  output logic [15:0] o_word [4],      // result words r to r+3
  output logic [7:0] o_n_wr            // writes seen
);
  import ubdiv_pkg::*;
  logic [15:0] word_q [4];
  logic [15:0] word_d [4];
  logic [7:0] n_wr_q;
  logic [7:0] n_wr_d;
  always_comb begin
    word_d = word_q;
    n_wr_d = n_wr_q;
    if (i_rst) begin
      word_d = '{default: 16'h0000};
      n_wr_d = 8'h00;
    end else if (i_wr_en) begin
      n_wr_d = n_wr_q + 8'h01;
      word_d[0] = i_rsp.quotient[15:0];
      if (i_rsp.words == 2'h2) begin
        word_d[1] = i_rsp.quotient[31:16];
        word_d[2] = i_rsp.remainder[15:0];
        word_d[3] = i_rsp.remainder[31:16];
      end else begin
        word_d[1] = i_rsp.remainder[15:0];
      end
    end
  end
  always_ff @(posedge i_clk) begin
    word_q <= word_d;
    n_wr_q <= n_wr_d;
  end
  assign o_word = word_q;
  assign o_n_wr = n_wr_q;
endmodule : ubdiv_mem

// [verif/tb.sv]
// bench: directed divides through the core, results caught by the memory
// assumes one request at a time, the next only after done
`timescale 1ns/10ps
module tb;
  import ubdiv_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  ubdiv_req_s req = '0;
  logic busy;
  logic done;
  logic wr_en;
  ubdiv_rsp_s rsp;
  logic [15:0] word [4];
  logic [7:0] n_wr;
  int n_fail = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  ubdiv_core DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_START(start),
    .I_REQ(req), .O_BUSY(busy), .O_DONE(done), .O_WR_EN(wr_en), .O_RSP(rsp));
  ubdiv_mem mem (.i_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_rsp(rsp),
    .o_word(word), .o_n_wr(n_wr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (exp !== got) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic is_bcd(input logic [31:0] v);
    for (int i = 0; i < 8; i++) if (v[4*i+:4] > 4'h9) return 1'b0;
    return 1'b1;
  endfunction : is_bcd
  function automatic longint to_int(input logic [31:0] v);
    longint s = 0;
    for (int i = 7; i >= 0; i--) s = s * 10 + v[4*i+:4];
    return s;
  endfunction : to_int
  function automatic logic [31:0] to_bcd(input longint n);
    logic [31:0] b = '0;
    for (int i = 0; i < 8; i++) begin
      b[4*i+:4] = 4'(n % 10);
      n = n / 10;
    end
    return b;
  endfunction : to_bcd
  // expectations are worked out here, never read back from the core
  task automatic divide(input logic [9:0] op, input logic [31:0] dd, dr);
    logic dbl, bcd, flt;
    logic [31:0] q, r, a, b;
    logic [15:0] old [4];
    logic [7:0] old_n;
    int i;
    dbl = (op == UBDIV_OP_UL) || (op == UBDIV_OP_BL);
    bcd = (op == UBDIV_OP_B) || (op == UBDIV_OP_BL);
    a = dbl ? dd : {16'h0000, dd[15:0]};
    b = dbl ? dr : {16'h0000, dr[15:0]};
    flt = (b == 0) || (bcd && !(is_bcd(a) && is_bcd(b)));
    if (!flt) begin
      q = bcd ? to_bcd(to_int(a) / to_int(b)) : a / b;
      r = bcd ? to_bcd(to_int(a) % to_int(b)) : a % b;
    end
    old = word;
    old_n = n_wr;
    @(negedge clk);
    req = '{op, dd, dr};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("busy", 32'h1, busy);
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 60);
    chk("done", 32'h1, done);
    chk("busy end", 32'h0, busy);
    chk("fault", flt, rsp.fault_flag_label);
    if (flt) begin
      chk("writes", old_n, n_wr);
      for (i = 0; i < 4; i++) chk("kept word", old[i], word[i]);
    end else begin
      chk("writes", old_n + 8'h01, n_wr);
      chk("word0", q[15:0], word[0]);
      chk("word1", dbl ? q[31:16] : r[15:0], word[1]);
      if (dbl) chk("word2 word3", r, {word[3], word[2]});
      chk("zero", q == 0, rsp.zero_flag_label);
      chk("neg", !bcd && (dbl ? q[31] : q[15]), rsp.negative);
    end
    // done stands for one cycle only
    @(posedge clk);
    #1;
    chk("done pulse", 32'h0, done);
  endtask : divide
  // an opcode outside the four divides must start nothing and write nothing
  task automatic t_refused;
    logic [7:0] old_n;
    int seen;
    old_n = n_wr;
    seen = 0;
    @(negedge clk);
    req = '{10'h1B4, 32'h0000_0010, 32'h0000_0002};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (busy !== 1'b0 || done !== 1'b0) seen++;
    end
    chk("ignored opcode", 32'h0, seen);
    chk("writes", old_n, n_wr);
  endtask : t_refused
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_zero_div;
    divide(UBDIV_OP_U, 32'h0001_0000, 32'h0001_0000);
    divide(UBDIV_OP_UL, 32'h1234_5678, 32'h0000_0000);
  endtask : t_zero_div
  task automatic t_unsigned;
    divide(UBDIV_OP_U, 32'h0000_1234, 32'h0000_0010);
    divide(UBDIV_OP_U, 32'hABCD_FFFF, 32'h0000_0001);
    divide(UBDIV_OP_UL, 32'h89AB_CDEF, 32'h0000_0003);
    divide(UBDIV_OP_UL, 32'hF000_0001, 32'h0000_0001);
    divide(UBDIV_OP_UL, 32'h0001_0000, 32'h0002_0000);
  endtask : t_unsigned
  task automatic t_bcd_single;
    divide(UBDIV_OP_B, 32'h0000_9876, 32'h0000_0123);
    divide(UBDIV_OP_B, 32'h0000_0005, 32'h0000_0009);
    divide(UBDIV_OP_B, 32'h0000_12A4, 32'h0000_0003);
    divide(UBDIV_OP_B, 32'h0000_0100, 32'h0000_0A00);
    divide(UBDIV_OP_B, 32'h0000_1234, 32'h0000_0000);
  endtask : t_bcd_single
  task automatic t_bcd_double;
    divide(UBDIV_OP_BL, 32'h9999_9999, 32'h0000_0007);
    divide(UBDIV_OP_BL, 32'h0000_0005, 32'h0000_0123);
    divide(UBDIV_OP_BL, 32'h1234_5678, 32'h00A0_0001);
    divide(UBDIV_OP_BL, 32'h0000_0001, 32'h0000_0000);
  endtask : t_bcd_double
  task automatic complete_run;
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_zero_div();
    t_unsigned();
    t_bcd_single();
    t_bcd_double();
    t_refused();
    complete_run();
  end
  // about 17 requests of under 50 cycles each, with a wide margin
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
endmodule : tb
